// ===== src/cqm_pkg.sv
package cqm_pkg;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] LIMIT_OFS  = 8'h04;
  localparam logic [7:0] ACCUM_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_RST_BIT = 3;
  localparam logic [1:0] SEL_REPORT = 2'h0;
  localparam logic [1:0] SEL_DISC   = 2'h1;
  localparam logic [1:0] SEL_SLEEP  = 2'h2;
  localparam logic [1:0] SEL_IGNORE = 2'h3;
  localparam logic [1:0] SEL_RESET  = SEL_DISC;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [1:0] STEP_IDLE   = 2'h0;
  localparam logic [1:0] STEP_FIRST  = 2'h1;
  localparam logic [1:0] STEP_SECOND = 2'h2;
  localparam logic [1:0] STEP_THIRD  = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 10000000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam logic [22:0] MA_MS_PER_MAH = 23'h36EE80;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_SLEEP  = 3'b001,
    PS_DETECT = 3'b010,
    PS_ACTIVE = 3'b100
  } cqm_pstate_e;

  typedef struct packed {
    logic mode_select_a;
    logic mode_select_b;
    logic emulation_enable_in;
    logic standby_bypass_select;
    logic port_power_enable_in;
  } cqm_pins_s;

  typedef struct packed {
    logic port_switch_on;
    logic bypass_on;
    logic emulation_on;
    logic emulation_restart;
    logic high_speed_data_switch;
    logic supply_monitor_on;
  } cqm_out_s;

endpackage : cqm_pkg

// ===== src/cqm_top.sv
`timescale 1ns/100ps
`default_nettype none
module cqm_top #(
  parameter int TICK_CYCLES = cqm_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // mode control pins and detection events
  input  wire cqm_pkg::cqm_pins_s pins_in,
  input  wire logic              removal_det_in,
  input  wire logic              attach_det_in,
  // measured port current, same clock domain
  input  wire logic [15:0]       port_current_ma,
  // open-drain alert pin
  input  wire logic              alert_in,
  output logic                   alert_out,
  output logic                   alert_oe_n,
  // port side controls
  output cqm_pkg::cqm_out_s      port_ctl,
  output cqm_pkg::cqm_pstate_e   power_state
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic [1:0] det_prev_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r     <= 8'h00;
      sync_r     <= 8'h00;
      det_prev_r <= 2'h0;
    end else begin
      meta_r     <= {alert_in, attach_det_in, removal_det_in, pins_in};
      sync_r     <= meta_r;
      det_prev_r <= sync_r[6:5];
    end
  end

  cqm_pkg::cqm_pins_s pins;
  wire removal_edge = sync_r[5] & ~det_prev_r[0];
  wire attach_edge  = sync_r[6] & ~det_prev_r[1];
  wire alert_level  = sync_r[7];
  assign pins = cqm_pkg::cqm_pins_s'(sync_r[4:0]);

  // ---------------------------------------------------------------
  // bus slave: one wait state so read data come from a flop
  // ---------------------------------------------------------------
  logic        dp_r;
  logic        dp_wr_r;
  logic [7:0]  dp_addr_r;
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  wire ap_take = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_r        <= 1'b0;
      dp_wr_r     <= 1'b0;
      dp_addr_r   <= 8'h00;
      hreadyout_r <= 1'b1;
    end else begin
      dp_r        <= ap_take;
      hreadyout_r <= ~ap_take;
      if (ap_take) begin
        dp_wr_r   <= hwrite;
        dp_addr_r <= haddr[7:0];
      end
    end
  end

  wire wr_ctrl  = dp_r & dp_wr_r & (dp_addr_r == cqm_pkg::CTRL_OFS);
  wire wr_limit = dp_r & dp_wr_r & (dp_addr_r == cqm_pkg::LIMIT_OFS);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic        enable_r;
  logic [1:0]  sel_r;
  logic [15:0] limit_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= 1'b0;
      sel_r    <= cqm_pkg::SEL_RESET;
      limit_r  <= cqm_pkg::LIMIT_RESET;
    end else begin
      if (wr_ctrl) begin
        enable_r <= hwdata[cqm_pkg::CTRL_EN_BIT];
        sel_r    <= hwdata[cqm_pkg::CTRL_SEL_LSB +: 2];
      end
      if (wr_limit) begin
        limit_r <= hwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // reset, disable and recovery decode
  // ---------------------------------------------------------------
  logic        reached_r;
  logic [1:0]  step_r;
  logic [15:0] mah_r;
  logic [21:0] frac_r;
  cqm_pkg::cqm_pstate_e state_r;
  cqm_pkg::cqm_pstate_e prev_r;
  cqm_pkg::cqm_pins_s   snap_r;

  wire rst_req  = wr_ctrl & hwdata[cqm_pkg::CTRL_RST_BIT];
  wire dis_req  = wr_ctrl & enable_r & ~hwdata[cqm_pkg::CTRL_EN_BIT];
  wire clear_w  = rst_req | dis_req;
  wire recover_w = reached_r & clear_w;
  wire resample_w = recover_w &
                    ((sel_r == cqm_pkg::SEL_DISC) |
                     (sel_r == cqm_pkg::SEL_SLEEP));
  wire changed_w  = (pins != snap_r);

  wire is_disc  = reached_r & (sel_r == cqm_pkg::SEL_DISC);
  wire is_sleep = reached_r & (sel_r == cqm_pkg::SEL_SLEEP);
  wire step_ge1 = (step_r >= cqm_pkg::STEP_FIRST);
  wire step_ge2 = (step_r >= cqm_pkg::STEP_SECOND);
  wire step_ge3 = (step_r == cqm_pkg::STEP_THIRD);

  // ---------------------------------------------------------------
  // charge accumulator
  // ---------------------------------------------------------------
  logic [31:0] tick_r;
  wire tick_w   = (tick_r == 32'(TICK_CYCLES - 1));
  wire active_w = (state_r == cqm_pkg::PS_ACTIVE);
  wire acc_en   = enable_r & active_w & ~reached_r;
  wire [22:0] sum_w  = {1'b0, frac_r} + {7'h00, port_current_ma};
  wire        roll_w = (sum_w >= cqm_pkg::MA_MS_PER_MAH);
  wire [22:0] rem_w  = sum_w - cqm_pkg::MA_MS_PER_MAH;
  wire        mah_max = (mah_r == 16'hFFFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_r <= 32'h00000000;
    end else if (tick_w) begin
      tick_r <= 32'h00000000;
    end else begin
      tick_r <= tick_r + 32'h00000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mah_r  <= 16'h0000;
      frac_r <= 22'h000000;
    end else if (clear_w) begin
      mah_r  <= 16'h0000;
      frac_r <= 22'h000000;
    end else if (tick_w & acc_en) begin
      frac_r <= roll_w ? rem_w[21:0] : sum_w[21:0];
      if (roll_w & ~mah_max) begin
        mah_r <= mah_r + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // limit detection and action sequencing
  // ---------------------------------------------------------------
  // limit compare; a zero limit trips at once
  wire reach_w = enable_r & active_w & ~reached_r & (mah_r >= limit_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reached_r <= 1'b0;
    end else if (reach_w) begin
      reached_r <= 1'b1;
    end else if (clear_w) begin
      reached_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_r <= cqm_pkg::STEP_IDLE;
    end else if (reach_w) begin
      step_r <= cqm_pkg::STEP_FIRST;
    end else if (clear_w) begin
      step_r <= cqm_pkg::STEP_IDLE;
    end else if (reached_r & ~step_ge3) begin
      step_r <= step_r + 2'h1;
    end
  end

  // snapshot for the later pin re-check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_r <= '0;
      prev_r <= cqm_pkg::PS_SLEEP;
    end else if (reach_w) begin
      snap_r <= pins;
      prev_r <= state_r;
    end
  end

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  wire sleep_cmd = ~pins.emulation_enable_in & ~pins.mode_select_a &
                   ~pins.mode_select_b;
  cqm_pkg::cqm_pstate_e ind_w;
  assign ind_w = sleep_cmd ? cqm_pkg::PS_SLEEP :
                 pins.port_power_enable_in ? cqm_pkg::PS_ACTIVE :
                 cqm_pkg::PS_DETECT;

  cqm_pkg::cqm_pstate_e state_nxt;
  always_comb begin
    state_nxt = ind_w;
    case ({resample_w, is_sleep})
      2'b10, 2'b11: begin
        // unchanged pins restore the old state
        state_nxt = changed_w ? ind_w : prev_r;
      end
      2'b01: begin
        state_nxt = step_ge3 ? cqm_pkg::PS_SLEEP : state_r;
      end
      default: begin
        // code 01 still follows the pins
        state_nxt = ind_w;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= cqm_pkg::PS_SLEEP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // port side outputs
  // ---------------------------------------------------------------
  logic removed_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      removed_r <= 1'b0;
    end else if (removal_edge) begin
      removed_r <= 1'b1;
    end else if (attach_edge) begin
      removed_r <= 1'b0;
    end
  end

  wire sw_block  = (is_disc & step_ge3) | (is_sleep & step_ge1);
  wire emu_block = (is_disc | is_sleep) & step_ge2;
  wire mon_block = is_sleep & step_ge1;
  wire byp_block = is_disc & step_ge3;
  wire rs_restart = resample_w & changed_w & pins.emulation_enable_in;
  wire re_attach  = attach_edge & removed_r & enable_r & ~reached_r;
  // alert for codes 00 and 01
  wire alert_drv  = reached_r & ((sel_r == cqm_pkg::SEL_REPORT) |
                                 (sel_r == cqm_pkg::SEL_DISC & step_ge1));

  cqm_pkg::cqm_out_s out_nxt;
  cqm_pkg::cqm_out_s out_r;
  logic              alert_oe_n_r;
  // no error path: the outputs below and power_state (forced to Sleep under code 10) react to the limit
  assign out_nxt.port_switch_on = (state_r == cqm_pkg::PS_ACTIVE) &
                                  ~sw_block;
  assign out_nxt.bypass_on      = (state_r == cqm_pkg::PS_DETECT) &
                                  pins.standby_bypass_select & ~byp_block;
  assign out_nxt.emulation_on   = pins.emulation_enable_in &
                                  (state_r != cqm_pkg::PS_SLEEP) &
                                  ~emu_block;
  assign out_nxt.emulation_restart = rs_restart | re_attach;
  // code 01 leaves the data switch to the state
  assign out_nxt.high_speed_data_switch = (state_r == cqm_pkg::PS_ACTIVE) &
                                          ~mon_block;
  assign out_nxt.supply_monitor_on = ~mon_block;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r        <= '0;
      alert_oe_n_r <= 1'b1;
    end else begin
      out_r        <= out_nxt;
      // alert released once the flag clears
      alert_oe_n_r <= ~alert_drv;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [31:0] ctrl_rd   = {28'h0000000, 1'b0, sel_r, enable_r};
  wire [31:0] limit_rd  = {16'h0000, limit_r};
  wire [31:0] accum_rd  = {16'h0000, mah_r};
  wire [31:0] status_rd = {22'h000000, alert_level,
                           out_r.supply_monitor_on,
                           out_r.high_speed_data_switch,
                           out_r.bypass_on, out_r.emulation_on,
                           out_r.port_switch_on, state_r, reached_r};
  wire [31:0] rd_mux = (dp_addr_r == cqm_pkg::CTRL_OFS)   ? ctrl_rd :
                       (dp_addr_r == cqm_pkg::LIMIT_OFS)  ? limit_rd :
                       (dp_addr_r == cqm_pkg::ACCUM_OFS)  ? accum_rd :
                       (dp_addr_r == cqm_pkg::STATUS_OFS) ? status_rd :
                       32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (dp_r & ~dp_wr_r) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hrdata      = hrdata_r;
  assign hreadyout   = hreadyout_r;
  assign hresp       = 1'b0;
  assign alert_out   = 1'b0;
  assign alert_oe_n  = alert_oe_n_r;
  assign port_ctl    = out_r;
  assign power_state = state_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  acc_only_active_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!active_w && !clear_w) |=> $stable(mah_r))
    else $error("charge changed outside the active state");

  flag_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    reach_w |=> reached_r && step_r == cqm_pkg::STEP_FIRST)
    else $error("reached flag not set at the limit");

  action_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (reached_r && !clear_w) |=> reached_r)
    else $error("rationing action dropped without reset");

  disc_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (reach_w && sel_r == cqm_pkg::SEL_DISC) ##1
    (!clear_w && !wr_ctrl)[*3] |=>
    !alert_oe_n_r && !out_r.emulation_on && !out_r.port_switch_on)
    else $error("disconnect sequence not completed");

  no_bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_disc && step_ge3) |=> !out_r.bypass_on)
    else $error("bypass turned on after the limit");

  hsw_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)
    is_disc |=> out_r.high_speed_data_switch ==
                ($past(state_r) == cqm_pkg::PS_ACTIVE))
    else $error("data switch disturbed under code 01");

  sleep_freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_sleep && step_ge3 && !resample_w) |=>
    state_r == cqm_pkg::PS_SLEEP && !out_r.supply_monitor_on)
    else $error("sleep not held under code 10");

  reset_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clear_w && !reach_w) |=> mah_r == 16'h0000 && !reached_r)
    else $error("rationing reset did not clear");

  alert_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (recover_w && !sel_r[1]) |-> ##2 alert_oe_n_r)
    else $error("alert not released after reset");

  restore_prev_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (resample_w && !changed_w) |=>
    state_r == $past(prev_r) && !out_r.emulation_restart)
    else $error("previous state not restored");

endmodule : cqm_top
`default_nettype wire

// ===== testbench/cqm_port_model.sv
`timescale 1ns/100ps
`default_nettype none
// attached portable device plus the pulled-up alert wire
module cqm_port_model (
  // draw request and the two supply switches
  input  wire logic        port_switch_on,
  input  wire logic        bypass_on,
  input  wire logic [15:0] draw_ma,
  output logic      [15:0] port_current_ma,
  // open-drain alert wire
  input  wire logic        alert_out,
  input  wire logic        alert_oe_n,
  output logic             alert_in
);
  // a device behind two open switches draws nothing
  assign port_current_ma = (port_switch_on | bypass_on) ? draw_ma : 16'h0000;
  // pull-up wins unless the pin is driven
  assign alert_in = alert_oe_n ? 1'b1 : alert_out;
endmodule : cqm_port_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  cqm_pkg::cqm_pins_s   pins_in;
  logic                 removal_det_in;
  logic                 attach_det_in;
  logic [15:0]          port_current_ma;
  logic [15:0]          draw_ma;
  logic                 alert_in;
  logic                 alert_out;
  logic                 alert_oe_n;
  cqm_pkg::cqm_out_s    port_ctl;
  cqm_pkg::cqm_pstate_e power_state;
  logic [31:0]          rdv;
  int                   mismatches;
  int                   compares;
  int                   restarts;
  int                   r;

  cqm_top #(.TICK_CYCLES(4)) cqm_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins_in(pins_in), .removal_det_in(removal_det_in),
    .attach_det_in(attach_det_in), .port_current_ma(port_current_ma),
    .alert_in(alert_in), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .port_ctl(port_ctl), .power_state(power_state));

  cqm_port_model cqm_port_model_inst (
    .port_switch_on(port_ctl.port_switch_on),
    .bypass_on(port_ctl.bypass_on), .draw_ma(draw_ma),
    .port_current_ma(port_current_ma), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .alert_in(alert_in));

  // ---------------------------------------------------------------
  // bus and helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h00000000);
  endtask : rd

  // control word: reset bit, action, enable
  task automatic ctl(input logic [1:0] s, input logic en, input logic rs);
    bus(cqm_pkg::CTRL_OFS, 1'b1, {28'h0000000, rs, s, en});
  endtask : ctl

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // polls until the masked read is nonzero, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((rdv & m) == 32'h0 && n < 400);
    cyc(6);
  endtask : poll

  task automatic pins(input logic [4:0] p);
    pins_in <= p;
    cyc(8);
  endtask : pins

  always @(posedge hclk) begin
    if (port_ctl.emulation_restart === 1'b1) restarts++;
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(cqm_pkg::CTRL_OFS);
    `CHK(rdv, 32'h00000002)
    rd(cqm_pkg::LIMIT_OFS);
    `CHK(rdv, 32'h00000000)
    rd(8'h40);
    `CHK(rdv, 32'h00000000)
    `CHK(hresp, 1'b0)
    $display("test regs done");
  endtask : t_regs

  task automatic t_report;
    bus(cqm_pkg::LIMIT_OFS, 1'b1, 32'h00000003);
    ctl(2'h0, 1'b1, 1'b0);
    poll(cqm_pkg::ACCUM_OFS, 32'h0000FFFF);
    r = restarts;
    removal_det_in <= 1'b1;
    cyc(4);
    removal_det_in <= 1'b0;
    attach_det_in  <= 1'b1;
    cyc(4);
    attach_det_in  <= 1'b0;
    cyc(6);
    rd(cqm_pkg::ACCUM_OFS);
    `CHK(rdv, 32'h00000001)
    `CHK(restarts, r + 1)
    ctl(2'h0, 1'b0, 1'b0);
    rd(cqm_pkg::ACCUM_OFS);
    `CHK(rdv, 32'h00000000)
    bus(cqm_pkg::LIMIT_OFS, 1'b1, 32'h00000001);
    ctl(2'h0, 1'b1, 1'b0);
    poll(cqm_pkg::STATUS_OFS, 32'h00000001);
    `CHK(alert_in, 1'b0)
    `CHK(port_ctl.port_switch_on, 1'b1)
    `CHK(power_state, cqm_pkg::PS_ACTIVE)
    `CHK(alert_out, 1'b0)
    rd(cqm_pkg::STATUS_OFS);
    `CHK(rdv[9], 1'b0)
    ctl(2'h0, 1'b0, 1'b0);
    rd(cqm_pkg::STATUS_OFS);
    `CHK(rdv[0], 1'b0)
    cyc(2);
    `CHK(alert_oe_n, 1'b1)
    $display("test report done");
  endtask : t_report

  task automatic t_disc;
    ctl(2'h1, 1'b1, 1'b0);
    poll(cqm_pkg::STATUS_OFS, 32'h00000001);
    `CHK(alert_oe_n, 1'b0)
    `CHK(port_ctl.emulation_on, 1'b0)
    `CHK(port_ctl.port_switch_on, 1'b0)
    `CHK(port_ctl.high_speed_data_switch, 1'b1)
    `CHK(port_ctl.supply_monitor_on, 1'b1)
    pins(5'b10110);
    `CHK(power_state, cqm_pkg::PS_DETECT)
    `CHK(port_ctl.bypass_on, 1'b0)
    `CHK(port_ctl.port_switch_on, 1'b0)
    rd(cqm_pkg::STATUS_OFS);
    `CHK(rdv[0], 1'b1)
    // same pins as at the limit: plain return, no restart
    pins(5'b10101);
    `CHK(power_state, cqm_pkg::PS_ACTIVE)
    `CHK(port_ctl.port_switch_on, 1'b0)
    r = restarts;
    ctl(2'h1, 1'b1, 1'b1);
    cyc(6);
    rd(cqm_pkg::ACCUM_OFS);
    `CHK(rdv, 32'h00000000)
    rd(cqm_pkg::STATUS_OFS);
    `CHK(rdv[0], 1'b0)
    `CHK(alert_oe_n, 1'b1)
    `CHK(power_state, cqm_pkg::PS_ACTIVE)
    `CHK(port_ctl.port_switch_on, 1'b1)
    `CHK(restarts, r)
    $display("test disconnect done");
  endtask : t_disc

  task automatic t_sleep;
    ctl(2'h2, 1'b1, 1'b1);
    poll(cqm_pkg::STATUS_OFS, 32'h00000001);
    `CHK(power_state, cqm_pkg::PS_SLEEP)
    `CHK(port_ctl.port_switch_on, 1'b0)
    `CHK(port_ctl.emulation_on, 1'b0)
    `CHK(port_ctl.high_speed_data_switch, 1'b0)
    `CHK(port_ctl.supply_monitor_on, 1'b0)
    pins(5'b10100);
    `CHK(power_state, cqm_pkg::PS_SLEEP)
    r = restarts;
    ctl(2'h2, 1'b1, 1'b1);
    cyc(8);
    `CHK(power_state, cqm_pkg::PS_DETECT)
    `CHK(restarts, r + 1)
    pins(5'b10101);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_ignore;
    ctl(2'h3, 1'b1, 1'b1);
    poll(cqm_pkg::STATUS_OFS, 32'h00000001);
    `CHK(alert_oe_n, 1'b1)
    `CHK(port_ctl.port_switch_on, 1'b1)
    `CHK(power_state, cqm_pkg::PS_ACTIVE)
    // outside Active nothing may accumulate
    ctl(2'h3, 1'b0, 1'b0);
    pins(5'b10110);
    ctl(2'h3, 1'b1, 1'b0);
    // bypass carries current, so only the state gate keeps charge at zero
    `CHK(port_ctl.bypass_on, 1'b1)
    cyc(400);
    rd(cqm_pkg::ACCUM_OFS);
    `CHK(rdv, 32'h00000000)
    $display("test ignore done");
  endtask : t_ignore

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    #3000000;
    mismatches++;
    conclude();
  end

  initial begin
    mismatches     = 0;
    compares       = 0;
    restarts       = 0;
    hresetn        = 1'b0;
    hsel           = 1'b0;
    haddr          = 32'h00000000;
    htrans         = 2'h0;
    hwrite         = 1'b0;
    hwdata         = 32'h00000000;
    pins_in        = 5'b10101;
    removal_det_in = 1'b0;
    attach_det_in  = 1'b0;
    draw_ma        = 16'hFFFF;
    cyc(6);
    hresetn <= 1'b1;
    cyc(8);
    t_regs();
    t_report();
    t_disc();
    t_sleep();
    t_ignore();
    conclude();
  end
endmodule : testbench
`default_nettype wire
